// >>> common/gpa_cfg.svh
// offsets, reset values and bit positions of the port a block
`ifndef GPA_CFG_SVH
`define GPA_CFG_SVH
`define GPA_OFF_PORT 8'h00
`define GPA_OFF_DIR 8'h04
`define GPA_OFF_ANSEL 8'h08
`define GPA_OFF_ALTPIN 8'h0c
`define GPA_OFF_BITSET 8'h10
`define GPA_OFF_BITCLR 8'h14
`define GPA_RST_DIR 8'hff
`define GPA_RST_ANSEL 8'hff
`define GPA_RST_ALTPIN 1'b0
`define GPA_ALTPIN_SS_POS 0
`define GPA_TMR_PIN 4
`define GPA_SS_PIN_DEF 5
`define GPA_SS_PIN_ALT 0
`endif

// >>> common/gpa_pin_if.sv
// pin side signals shared by the port a modules
`timescale 1ns/1ps
interface gpa_pin_if;
  import gpa_pkg::*;
  gpa_byte_t latch;
  gpa_byte_t dir;
  gpa_byte_t ansel;
  logic slave_select_pin_choice;
  gpa_byte_t pin_in;
  gpa_byte_t pin_out;
  gpa_byte_t pin_oe;
  gpa_byte_t dig_in;
  logic tmr_clk;
  logic ss_in;
  modport pad (
    input latch,
    input dir,
    input ansel,
    input pin_in,
    output pin_out,
    output pin_oe,
    output dig_in
  );
  modport route (
    input dig_in,
    input pin_in,
    input slave_select_pin_choice,
    output tmr_clk,
    output ss_in
  );
endinterface : gpa_pin_if

// >>> common/gpa_pkg.sv
// types of the port a block
package gpa_pkg;
  typedef enum logic [1:0] {
    GPA_OP_IDLE,
    GPA_OP_WRITE,
    GPA_OP_READ
  } gpa_op_t;
  typedef logic [7:0] gpa_byte_t;
  typedef struct packed {
    gpa_byte_t dir;
    gpa_byte_t ansel;
    logic slave_select_pin_choice;
    gpa_op_t op;
    gpa_byte_t addr;
    gpa_byte_t rdata;
  } gpa_state_t;
endpackage : gpa_pkg

// >>> design/gpa_alt_route.sv
// timer clock and slave select routing off port a pins
`timescale 1ns/1ps
`include "gpa_cfg.svh"
module gpa_alt_route (
  gpa_pin_if.route pins
);
  import gpa_pkg::*;
  // ==========================================
  // timer clock taken from the pad whatever the direction
  assign pins.tmr_clk = pins.dig_in[`GPA_TMR_PIN];
  // ==========================================
  // slave select on one of two pins
  assign pins.ss_in = pins.slave_select_pin_choice ? pins.dig_in[`GPA_SS_PIN_ALT]
                                 : pins.dig_in[`GPA_SS_PIN_DEF];
endmodule : gpa_alt_route

// >>> design/gpa_pad_bank.sv
// per-pin driver and digital input buffer of port a
`timescale 1ns/1ps
module gpa_pad_bank #(
  parameter int WIDTH = 8
) (
  gpa_pin_if.pad pins
);
  import gpa_pkg::*;
  // ==========================================
  // one cell per pin
  for (genvar i = 0; i < WIDTH; i++) begin : g_cell
    // driver follows the direction bit only
    assign pins.pin_oe[i] = ~pins.dir[i];
    assign pins.pin_out[i] = pins.latch[i];
    // analog pins read as zero
    assign pins.dig_in[i] = pins.pin_in[i] & ~pins.ansel[i];
  end
endmodule : gpa_pad_bank

// >>> design/gpa_top.sv
// port a general purpose io block with ahb-lite register slave
// Function
// - eight pins, each usable as input or output
// - direction one turns the pin driver off
// - direction zero drives the latch onto the pin
// - port read returns sampled pin levels
// - port write updates the output latch
// - bit set and bit clear writes sample pins, modify, store whole latch
// - direction controls driver even for analog pins
// - analog pins read zero on digital reads
// - analog select zero digital, one analog
// - analog select never blocks digital output
// - timer pin clocks timer regardless of direction
// - every reset sets all direction bits
// - every reset sets all analog select bits
// - slave select routable to pin five or zero
// - choice zero pin five, one pin zero
`timescale 1ns/1ps
`include "gpa_cfg.svh"
module gpa_top #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire gpa_pkg::gpa_byte_t pad_in,
  output gpa_pkg::gpa_byte_t pad_out,
  output gpa_pkg::gpa_byte_t pad_oe,
  output logic timer_zero_clock_in,
  output logic slave_select_in
);
  import gpa_pkg::*;

  // ==========================================
  // state
  gpa_state_t st_r;
  gpa_state_t st_nxt;
  gpa_byte_t latch_r;
  gpa_byte_t latch_nxt;
  logic access;
  gpa_byte_t wbyte;
  gpa_byte_t sampled;
  gpa_byte_t addr_lo;

  gpa_pin_if pins ();

  // ==========================================
  // pin side
  assign pins.latch = latch_r;
  assign pins.dir = st_r.dir;
  assign pins.ansel = st_r.ansel;
  assign pins.slave_select_pin_choice = st_r.slave_select_pin_choice;
  assign pins.pin_in = pad_in;

  gpa_pad_bank #(
    .WIDTH(WIDTH)
  ) u_pad (
    .pins(pins.pad)
  );

  gpa_alt_route u_route (
    .pins(pins.route)
  );

  assign pad_out = pins.pin_out;
  assign pad_oe = pins.pin_oe;
  assign timer_zero_clock_in = pins.tmr_clk;
  assign slave_select_in = pins.ss_in;

  // ==========================================
  // bus answers
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = {24'h00_0000, st_r.rdata};

  // ==========================================
  // address phase decode
  assign access = hsel & htrans[1] & hready;
  assign addr_lo = haddr[7:0];
  assign wbyte = hwdata[7:0];
  // pins as the digital buffers see them
  assign sampled = pins.dig_in;

  // ==========================================
  // next state
  always_comb begin
    st_nxt = st_r;
    latch_nxt = latch_r;
    // data phase of a write
    if (st_r.op == GPA_OP_WRITE) begin
      if (st_r.addr == `GPA_OFF_PORT) begin
        latch_nxt = wbyte;
      end else if (st_r.addr == `GPA_OFF_DIR) begin
        st_nxt.dir = wbyte;
      end else if (st_r.addr == `GPA_OFF_ANSEL) begin
        st_nxt.ansel = wbyte;
      end else if (st_r.addr == `GPA_OFF_ALTPIN) begin
        st_nxt.slave_select_pin_choice = wbyte[`GPA_ALTPIN_SS_POS];
      end else if (st_r.addr == `GPA_OFF_BITSET) begin
        latch_nxt = sampled | wbyte;
      end else if (st_r.addr == `GPA_OFF_BITCLR) begin
        latch_nxt = sampled & ~wbyte;
      end else begin
        latch_nxt = latch_r;
      end
    end
    // address phase, register read data prepared from post-write values, port read data from the pins as sampled now
    st_nxt.op = GPA_OP_IDLE;
    st_nxt.addr = addr_lo;
    if (access) begin
      st_nxt.op = hwrite ? GPA_OP_WRITE : GPA_OP_READ;
    end
    st_nxt.rdata = st_r.rdata;
    if (access && !hwrite) begin
      if (addr_lo == `GPA_OFF_PORT) begin
        st_nxt.rdata = sampled;
      end else if (addr_lo == `GPA_OFF_DIR) begin
        st_nxt.rdata = st_nxt.dir;
      end else if (addr_lo == `GPA_OFF_ANSEL) begin
        st_nxt.rdata = st_nxt.ansel;
      end else if (addr_lo == `GPA_OFF_ALTPIN) begin
        st_nxt.rdata = {7'h00, st_nxt.slave_select_pin_choice};
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r.dir <= `GPA_RST_DIR;
      st_r.ansel <= `GPA_RST_ANSEL;
      st_r.slave_select_pin_choice <= `GPA_RST_ALTPIN;
      st_r.op <= GPA_OP_IDLE;
      st_r.addr <= 8'h00;
      st_r.rdata <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  // latch keeps whatever it held across reset
  always_ff @(posedge clock) begin
    latch_r <= latch_nxt;
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  a_dir_off_drv: assert property (
    (pad_oe & st_r.dir) == 8'h00
  ) else $error("driver on while direction is input");

  a_dir_on_drv: assert property (
    (st_r.dir != 8'hff) |-> ((pad_out ^ latch_r) & ~st_r.dir) == 8'h00
      && (pad_oe | st_r.dir) == 8'hff
  ) else $error("output pin not driven from latch");

  a_port_read: assert property (
    (access && !hwrite && addr_lo == `GPA_OFF_PORT)
      |=> hrdata == {24'h00_0000, $past(pad_in & ~st_r.ansel)}
  ) else $error("port read not equal to sampled pins");

  a_port_write: assert property (
    (access && hwrite && addr_lo == `GPA_OFF_PORT)
      ##1 hready |=> latch_r == $past(hwdata[7:0])
  ) else $error("port write did not reach latch");

  a_bit_set_rmw: assert property (
    (st_r.op == GPA_OP_WRITE && st_r.addr == `GPA_OFF_BITSET)
      |=> latch_r == ($past(pad_in & ~st_r.ansel) | $past(hwdata[7:0]))
  ) else $error("bit set not built from sampled pins");

  a_analog_zero: assert property (
    (st_r.op == GPA_OP_WRITE && st_r.addr == `GPA_OFF_BITCLR
      && st_r.ansel == 8'hff)
      |=> latch_r == 8'h00
  ) else $error("analog pin sampled nonzero in modify");

  a_analog_drive: assert property (
    (st_r.dir == 8'h00 && st_r.ansel == 8'hff)
      |-> pad_oe == 8'hff && pad_out == latch_r
  ) else $error("analog select blocked output");

  a_analog_dir: assert property (
    $changed(st_r.ansel) && $stable(st_r.dir) |-> $stable(pad_oe)
  ) else $error("analog select changed driver");

  a_tmr_clock: assert property (
    timer_zero_clock_in == (pad_in[`GPA_TMR_PIN]
      & ~st_r.ansel[`GPA_TMR_PIN])
  ) else $error("timer clock not taken from pin");

  a_ss_route: assert property (
    slave_select_in == (st_r.slave_select_pin_choice
      ? (pad_in[`GPA_SS_PIN_ALT] & ~st_r.ansel[`GPA_SS_PIN_ALT])
      : (pad_in[`GPA_SS_PIN_DEF] & ~st_r.ansel[`GPA_SS_PIN_DEF]))
  ) else $error("slave select routed from wrong pin");

  a_reset_vals: assert property (
    $rose(rstn) |-> st_r.dir == 8'hff && st_r.ansel == 8'hff
      && pad_oe == 8'h00
  ) else $error("direction or analog select not reset");

  a_reg_readback: assert property (
    (access && !hwrite && addr_lo == `GPA_OFF_ANSEL
      && st_r.op == GPA_OP_IDLE)
      |=> hrdata[7:0] == $past(st_r.ansel)
  ) else $error("analog select readback wrong");

  // ==========================================
  // bus side checks
  a_hresp_okay: assert property (
    hresp == 1'b0 && hreadyout == 1'b1
  ) else $error("bus answer not ready and okay");

  a_rdata_upper: assert property (
    hrdata[31:8] == 24'h00_0000
  ) else $error("read data upper bits not zero");

  a_op_idle: assert property (
    !access |=> st_r.op == GPA_OP_IDLE
  ) else $error("data phase without address phase");

  a_op_write: assert property (
    (access && hwrite) |=> st_r.op == GPA_OP_WRITE
  ) else $error("write address phase not taken");

  a_op_read: assert property (
    (access && !hwrite) |=> st_r.op == GPA_OP_READ
  ) else $error("read address phase not taken");

  a_addr_track: assert property (
    access |=> st_r.addr == $past(addr_lo)
  ) else $error("data phase address lost");

  a_rdata_hold: assert property (
    !(access && !hwrite) |=> $stable(hrdata)
  ) else $error("read data changed without a read");

  a_unmapped_read: assert property (
    (access && !hwrite && addr_lo != `GPA_OFF_PORT
      && addr_lo != `GPA_OFF_DIR && addr_lo != `GPA_OFF_ANSEL
      && addr_lo != `GPA_OFF_ALTPIN)
      |=> hrdata == 32'h0000_0000
  ) else $error("unmapped read not zero");

  a_dir_readback: assert property (
    (access && !hwrite && addr_lo == `GPA_OFF_DIR
      && st_r.op == GPA_OP_IDLE)
      |=> hrdata[7:0] == $past(st_r.dir)
  ) else $error("direction readback wrong");

  a_choice_readback: assert property (
    (access && !hwrite && addr_lo == `GPA_OFF_ALTPIN
      && st_r.op == GPA_OP_IDLE)
      |=> hrdata == {31'h0000_0000, $past(st_r.slave_select_pin_choice)}
  ) else $error("pin choice readback wrong");

  a_analog_read_zero: assert property (
    (access && !hwrite && addr_lo == `GPA_OFF_PORT
      && st_r.ansel == 8'hff)
      |=> hrdata == 32'h0000_0000
  ) else $error("analog pins read nonzero");

  // ==========================================
  // register write checks
  a_dir_write: assert property (
    (access && hwrite && addr_lo == `GPA_OFF_DIR)
      ##1 hready |=> st_r.dir == $past(hwdata[7:0])
  ) else $error("direction write lost");

  a_ansel_write: assert property (
    (access && hwrite && addr_lo == `GPA_OFF_ANSEL)
      ##1 hready |=> st_r.ansel == $past(hwdata[7:0])
  ) else $error("analog select write lost");

  a_choice_write: assert property (
    (access && hwrite && addr_lo == `GPA_OFF_ALTPIN)
      ##1 hready |=> st_r.slave_select_pin_choice == $past(hwdata[`GPA_ALTPIN_SS_POS])
  ) else $error("pin choice write lost");

  a_dir_hold: assert property (
    !(st_r.op == GPA_OP_WRITE && st_r.addr == `GPA_OFF_DIR)
      |=> $stable(st_r.dir)
  ) else $error("direction changed without write");

  a_ansel_hold: assert property (
    !(st_r.op == GPA_OP_WRITE && st_r.addr == `GPA_OFF_ANSEL)
      |=> $stable(st_r.ansel)
  ) else $error("analog select changed without write");

  a_choice_hold: assert property (
    !(st_r.op == GPA_OP_WRITE && st_r.addr == `GPA_OFF_ALTPIN)
      |=> $stable(st_r.slave_select_pin_choice)
  ) else $error("pin choice changed without write");

  a_port_only_latch: assert property (
    (st_r.op == GPA_OP_WRITE && st_r.addr == `GPA_OFF_PORT)
      |=> $stable(st_r.dir) && $stable(st_r.ansel)
  ) else $error("port write touched control registers");

  // ==========================================
  // modify and pin checks
  a_bit_clr_rmw: assert property (
    (st_r.op == GPA_OP_WRITE && st_r.addr == `GPA_OFF_BITCLR)
      |=> latch_r == ($past(pad_in & ~st_r.ansel) & ~$past(hwdata[7:0]))
  ) else $error("bit clear not built from sampled pins");

  a_bit_set_analog: assert property (
    (st_r.op == GPA_OP_WRITE && st_r.addr == `GPA_OFF_BITSET
      && st_r.ansel == 8'hff)
      |=> latch_r == $past(hwdata[7:0])
  ) else $error("analog pin sampled nonzero in bit set");

  a_oe_follow: assert property (
    pad_oe == ~st_r.dir
  ) else $error("driver enable not inverse of direction");

  a_analog_alt_zero: assert property (
    st_r.ansel == 8'hff |-> !timer_zero_clock_in && !slave_select_in
  ) else $error("analog pins feed alternate inputs");

  a_tmr_out_pin: assert property (
    (!st_r.dir[`GPA_TMR_PIN] && !st_r.ansel[`GPA_TMR_PIN])
      |-> timer_zero_clock_in == pad_in[`GPA_TMR_PIN]
  ) else $error("driven timer pin not clocking timer");

  a_ss_choice_zero: assert property (
    (!st_r.slave_select_pin_choice && !st_r.ansel[`GPA_SS_PIN_DEF])
      |-> slave_select_in == pad_in[`GPA_SS_PIN_DEF]
  ) else $error("slave select not from pin five");

  a_ss_choice_one: assert property (
    (st_r.slave_select_pin_choice && !st_r.ansel[`GPA_SS_PIN_ALT])
      |-> slave_select_in == pad_in[`GPA_SS_PIN_ALT]
  ) else $error("slave select not from pin zero");

endmodule : gpa_top

// >>> sim/gpa_pins_model.sv
// external pin model for port a
`timescale 1ns/1ps
module gpa_pins_model (
  input wire gpa_pkg::gpa_byte_t drv,
  input wire gpa_pkg::gpa_byte_t oe,
  input wire gpa_pkg::gpa_byte_t ext,
  output gpa_pkg::gpa_byte_t lvl
);
  import gpa_pkg::*;
  // driven pins show the pad, released pins the outside level
  assign lvl = (drv & oe) | (ext & ~oe);
endmodule : gpa_pins_model

// >>> sim/tb_top.sv
// testbench of the port a block
`timescale 1ns/1ps
`include "gpa_cfg.svh"
module tb_top;
  import gpa_pkg::*;
  logic clock, rstn, hsel, hwrite, hreadyout, hresp, tmr, ss;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  gpa_byte_t pad_in, pad_out, pad_oe, ext;
  int bad_count, n_compared;
  gpa_top u_gpa_top (.clock(clock), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .timer_zero_clock_in(tmr), .slave_select_in(ss));
  gpa_pins_model u_gpa_pins_model (.drv(pad_out), .oe(pad_oe),
    .ext(ext), .lvl(pad_in));
  // ==========================================
  // bus and compare tasks
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata;
    hsel <= 1'b0;
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
    @(negedge clock);
  endtask : bus
  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk(r, {24'h00_0000, e});
  endtask : rd
  // ==========================================
  // scenarios
  task t_reset;
    rd(`GPA_OFF_DIR, 8'hff);
    rd(`GPA_OFF_ANSEL, 8'hff);
    rd(`GPA_OFF_ALTPIN, 8'h00);
    chk(pad_oe, 8'h00);
    ext = 8'hff;
    rd(`GPA_OFF_PORT, 8'h00);
    chk(tmr, 1'b0);
  endtask : t_reset
  task t_drive;
    wr(`GPA_OFF_ANSEL, 8'h00);
    wr(`GPA_OFF_PORT, 8'ha5);
    chk(pad_oe, 8'h00);
    ext = 8'h3c;
    wr(`GPA_OFF_DIR, 8'h0f);
    chk(pad_oe, 8'hf0);
    chk(pad_out, 8'ha5);
    rd(`GPA_OFF_PORT, 8'hac);
    rd(`GPA_OFF_DIR, 8'h0f);
  endtask : t_drive
  task t_analog;
    wr(`GPA_OFF_DIR, 8'h00);
    wr(`GPA_OFF_ANSEL, 8'hf0);
    chk(pad_oe, 8'hff);
    chk(pad_out, 8'ha5);
    rd(`GPA_OFF_PORT, 8'h05);
    wr(`GPA_OFF_BITSET, 8'h01);
    chk(pad_out, 8'h05);
    wr(`GPA_OFF_BITCLR, 8'h04);
    chk(pad_out, 8'h01);
  endtask : t_analog
  task t_timer;
    wr(`GPA_OFF_ANSEL, 8'h00);
    wr(`GPA_OFF_DIR, 8'hef);
    wr(`GPA_OFF_PORT, 8'h10);
    chk(tmr, 1'b1);
    wr(`GPA_OFF_PORT, 8'h00);
    chk(tmr, 1'b0);
    ext = 8'h00;
    wr(`GPA_OFF_DIR, 8'hff);
    chk(tmr, 1'b0);
    ext = 8'h10;
    #1;
    chk(tmr, 1'b1);
  endtask : t_timer
  task t_slave;
    ext = 8'h20;
    #1;
    chk(ss, 1'b1);
    wr(`GPA_OFF_ALTPIN, 8'h01);
    chk(ss, 1'b0);
    ext = 8'h01;
    #1;
    chk(ss, 1'b1);
    wr(`GPA_OFF_ANSEL, 8'h01);
    chk(ss, 1'b0);
    rd(`GPA_OFF_ALTPIN, 8'h01);
    wr(8'h18, 8'hff);
    rd(8'h18, 8'h00);
    rd(`GPA_OFF_BITSET, 8'h00);
  endtask : t_slave
  task t_rerun;
    wr(`GPA_OFF_PORT, 8'h5a);
    chk(pad_out, 8'h5a);
    @(posedge clock);
    rstn <= 1'b0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    rd(`GPA_OFF_DIR, 8'hff);
    rd(`GPA_OFF_ANSEL, 8'hff);
    chk(pad_out, 8'h5a);
  endtask : t_rerun
  task report_and_stop;
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================
  // clock, reset, sequence, watchdog
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    ext = 8'h00;
    bad_count = 0;
    n_compared = 0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    t_reset;
    t_drive;
    t_analog;
    t_timer;
    t_slave;
    t_rerun;
    report_and_stop;
  end
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    report_and_stop;
  end
endmodule : tb_top
